// ==== design/bsb_pkg.sv ====
// Shared constants and types for the branch, skip and bit execution slice.
`default_nettype none

package bsb_pkg;

	// ------------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------------
	localparam int PC_W = 16;
	localparam int OFS_W = 12;

	// ------------------------------------------------------------------
	// Register map, byte addresses on the Wishbone bus
	// ------------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_FLAGS = 8'h04;
	localparam logic [7:0] OFF_STAT = 8'h08;
	localparam logic [7:0] OFF_COUNT = 8'h0C;
	localparam int CTRL_EN_BIT = 0;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_IOERR_BIT = 1;
	localparam logic CTRL_EN_RST = 1'b1;
	localparam logic [7:0] FLAGS_RST = 8'h00;

	// ------------------------------------------------------------------
	// Status flags register bit positions
	// ------------------------------------------------------------------
	localparam logic [2:0] FL_C = 3'h0;
	localparam logic [2:0] FL_Z = 3'h1;
	localparam logic [2:0] FL_N = 3'h2;
	localparam logic [2:0] FL_V = 3'h3;
	localparam logic [2:0] FL_S = 3'h4;
	localparam logic [2:0] FL_H = 3'h5;
	localparam logic [2:0] FL_T = 3'h6;
	localparam logic [2:0] FL_I = 3'h7;

	// ------------------------------------------------------------------
	// Cycle counts and limits
	// ------------------------------------------------------------------
	localparam logic [2:0] CYC_ONE = 3'h1;
	localparam logic [2:0] CYC_JUMP = 3'h2;
	localparam logic [2:0] CYC_CALL = 3'h3;
	localparam logic [2:0] CYC_RET = 3'h4;
	localparam logic [2:0] CYC_IOBIT = 3'h2;
	localparam logic [2:0] CYC_SKIP1 = 3'h2;
	localparam logic [2:0] CYC_SKIP2 = 3'h3;
	localparam logic [5:0] IO_BIT_LIMIT = 6'h1F;

	// ------------------------------------------------------------------
	// Operations issued by the decoder
	// ------------------------------------------------------------------
	typedef enum logic [5:0] {
		op_nop = 6'h00,
		op_clear_bits_immediate = 6'h01,
		op_test_sign_zero = 6'h02,
		op_zero_register = 6'h03,
		op_indirect_jump = 6'h04,
		op_indirect_subroutine_call = 6'h05,
		op_relative_jump = 6'h06,
		op_relative_subroutine_call = 6'h07,
		op_subroutine_exit = 6'h08,
		op_interrupt_exit = 6'h09,
		op_compare_skip_equal = 6'h0A,
		op_compare_immediate = 6'h0B,
		op_skip_reg_bit_clear = 6'h0C,
		op_skip_reg_bit_set = 6'h0D,
		op_skip_io_bit_clear = 6'h0E,
		op_skip_io_bit_set = 6'h0F,
		op_branch_flag_set = 6'h10,
		op_branch_flag_clear = 6'h11,
		op_branch_signed_ge = 6'h12,
		op_branch_signed_less = 6'h13,
		op_branch_unsigned_higher_same = 6'h14,
		op_branch_unsigned_lower = 6'h15,
		op_branch_half_carry_set = 6'h16,
		op_branch_half_carry_clear = 6'h17,
		op_branch_transfer_bit_set = 6'h18,
		op_branch_transfer_bit_clear = 6'h19,
		op_branch_overflow_set = 6'h1A,
		op_branch_overflow_clear = 6'h1B,
		op_branch_irq_enabled = 6'h1C,
		op_branch_irq_disabled = 6'h1D,
		op_set_io_bit = 6'h1E,
		op_clear_io_bit = 6'h1F,
		op_shift_left_logical = 6'h20,
		op_shift_right_logical = 6'h21
	} bsb_op_t;

	// Execution state, Gray coded.
	typedef enum logic [0:0] {
		st_idle = 1'b0,
		st_run = 1'b1
	} bsb_state_t;

endpackage : bsb_pkg

`default_nettype wire

// ==== design/bsb_exec.sv ====
// Execution slice for logic tests, branches, skips, I/O bit ops and shifts.
//
// Added by the designer: the Wishbone register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Bit clear immediate ANDs register with inverted constant; Z,N,V; one cycle.
// - Test ANDs register with itself, value kept; Z,N,V; one cycle.
// - Register clear XORs register with itself giving zero; Z,N,V; one cycle.
// - Indirect jump loads PC from Z pair, flags kept, two cycles.
// - Indirect call loads PC from Z pair, flags kept, three cycles.
// - Compare-skip on equal advances PC by 2 or 3; 1/2/3 cycles.
// - Compare immediate subtracts without writing; Z,N,V,C,H; one cycle.
// - Skip when selected register bit is 0; PC plus 2 or 3.
// - Skip when selected register bit is 1; flags kept.
// - I/O bit skips test an I/O bit for 0 or 1; 1/2/3 cycles.
// - Branch when chosen flag is 0 to PC+k+1; one or two cycles.
// - Branch when chosen flag is 1 to PC+k+1, else sequential.
// - Signed branches use N XOR V: 0 for ge, 1 for less.
// - Unsigned branches: same-or-higher on C=0, lower on C=1.
// - Half-carry branches taken on H=1 or H=0; one or two cycles.
// - Transfer-bit branches test T for 1 or 0; flags kept.
// - Overflow branches taken on V=1 or V=0 to PC+k+1.
// - Interrupt-state branches taken on I=1 or I=0; one or two cycles.
// - Set I/O bit forces one bit to 1 in two cycles.
// - Clear I/O bit forces one bit to 0 in two cycles.
// - Left shift moves bits up, loads 0 in bit 0; Z,C,N,V.
// - Right shift moves bits down, loads 0 in bit 7; Z,C,N,V.
// - I/O bit operations only reach I/O addresses up to 0x1F.
// - I/O set and clear touch only the addressed bit.
module bsb_exec (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Wishbone slave
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [7:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [31:0] wb_dat_wr,
	output logic [31:0] wb_dat_rd,
	output logic wb_ack,
	// Issue from the decoder
	input wire logic issue_valid,
	output logic issue_ready,
	input wire bsb_pkg::bsb_op_t issue_op,
	input wire logic [bsb_pkg::PC_W-1:0] issue_pc,
	input wire logic [7:0] rd_val,
	input wire logic [7:0] rr_val,
	input wire logic [7:0] imm_val,
	input wire logic [2:0] bit_sel,
	input wire logic [bsb_pkg::OFS_W-1:0] rel_offset,
	input wire logic next_two_word,
	input wire logic [bsb_pkg::PC_W-1:0] z_ptr,
	input wire logic [bsb_pkg::PC_W-1:0] stack_pc,
	input wire logic [5:0] io_addr,
	input wire logic [7:0] io_rd_val,
	// Completion toward the datapath
	output logic done,
	output logic [bsb_pkg::PC_W-1:0] pc_next,
	output logic [7:0] result,
	output logic result_we,
	output logic [7:0] flags,
	output logic stack_push,
	output logic [bsb_pkg::PC_W-1:0] push_pc,
	output logic stack_pop,
	output logic io_bit_we,
	output logic [4:0] io_bit_addr,
	output logic [2:0] io_bit_index,
	output logic io_bit_val
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		bsb_pkg::bsb_state_t st;
		logic [2:0] cnt;
		logic done;
		logic ack;
		logic [31:0] rdat;
		logic ctrl_en;
		logic [7:0] status_flags_register;
		logic io_err;
		logic [15:0] retired;
		logic [bsb_pkg::PC_W-1:0] pc_next;
		logic [7:0] result;
		logic pend_rwe;
		logic pend_push;
		logic pend_pop;
		logic pend_io;
		logic [bsb_pkg::PC_W-1:0] push_pc;
		logic [4:0] io_addr;
		logic [2:0] io_idx;
		logic io_val;
	} bsb_regs_t;

	bsb_regs_t state_reg;
	bsb_regs_t state_next;
	logic accept;

	// Picks one bit of a byte; used for register, I/O and flag tests.
	function automatic logic bsb_bit(input logic [7:0] v, input logic [2:0] i);
		bsb_bit = v[i];
	endfunction : bsb_bit

	// Z, N and V after a logic operation; V always clears.
	function automatic logic [7:0] bsb_logic_flags(input logic [7:0] f,
			input logic [7:0] r);
		logic [7:0] o;
		o = f;
		o[bsb_pkg::FL_Z] = (r == 8'h00);
		o[bsb_pkg::FL_N] = r[7];
		o[bsb_pkg::FL_V] = 1'b0;
		bsb_logic_flags = o;
	endfunction : bsb_logic_flags

	// ------------------------------------------------------------------
	// Handshake and outputs
	// ------------------------------------------------------------------
	// Ready only when idle and enabled, so a disabled slice holds issue off.
	assign issue_ready = (state_reg.st == bsb_pkg::st_idle) && state_reg.ctrl_en;
	assign accept = issue_valid && issue_ready;
	assign wb_ack = state_reg.ack;
	assign wb_dat_rd = state_reg.rdat;
	assign done = state_reg.done;
	assign pc_next = state_reg.pc_next;
	assign result = state_reg.result;
	assign flags = state_reg.status_flags_register;
	assign push_pc = state_reg.push_pc;
	assign io_bit_addr = state_reg.io_addr;
	assign io_bit_index = state_reg.io_idx;
	assign io_bit_val = state_reg.io_val;
	// Side effects fire together with completion, not at issue.
	assign result_we = state_reg.done && state_reg.pend_rwe;
	assign stack_push = state_reg.done && state_reg.pend_push;
	assign stack_pop = state_reg.done && state_reg.pend_pop;
	assign io_bit_we = state_reg.done && state_reg.pend_io;

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	// Decode, execute and register bus in one pass; the flag update by an
	// accepted instruction wins over a software write in the same cycle.
	always_comb begin
		logic [2:0] cyc;
		logic [bsb_pkg::PC_W-1:0] seq;
		logic [bsb_pkg::PC_W-1:0] rel;
		logic [bsb_pkg::PC_W-1:0] npc;
		logic [7:0] res;
		logic [7:0] fl;
		logic [8:0] diff;
		logic take;
		logic rwe;
		logic fupd;
		logic push;
		logic pop;
		logic iow;
		logic ioerr;
		logic io_ok;
		logic [7:0] sr;
		cyc = bsb_pkg::CYC_ONE;
		seq = issue_pc + 16'h0001;
		rel = issue_pc + {{(bsb_pkg::PC_W-bsb_pkg::OFS_W){rel_offset[11]}},
			rel_offset} + 16'h0001;
		npc = seq;
		res = rd_val;
		sr = state_reg.status_flags_register;
		fl = sr;
		diff = {1'b0, rd_val} - {1'b0, imm_val};
		take = 1'b0;
		rwe = 1'b0;
		fupd = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		iow = 1'b0;
		ioerr = 1'b0;
		io_ok = ({1'b0, io_addr} <= {1'b0, bsb_pkg::IO_BIT_LIMIT});
		state_next = state_reg;
		state_next.done = 1'b0;

		unique case (issue_op)
			bsb_pkg::op_clear_bits_immediate: begin
				res = rd_val & ~imm_val;
				rwe = 1'b1;
				fupd = 1'b1;
				fl = bsb_logic_flags(sr, res);
			end
			bsb_pkg::op_test_sign_zero: begin
				res = rd_val & rd_val;
				fupd = 1'b1;
				fl = bsb_logic_flags(sr, res);
			end
			bsb_pkg::op_zero_register: begin
				res = rd_val ^ rd_val;
				rwe = 1'b1;
				fupd = 1'b1;
				fl = bsb_logic_flags(sr, res);
			end
			bsb_pkg::op_indirect_jump: begin
				npc = z_ptr;
				cyc = bsb_pkg::CYC_JUMP;
			end
			bsb_pkg::op_indirect_subroutine_call: begin
				npc = z_ptr;
				push = 1'b1;
				cyc = bsb_pkg::CYC_CALL;
			end
			bsb_pkg::op_relative_jump: begin
				npc = rel;
				cyc = bsb_pkg::CYC_JUMP;
			end
			bsb_pkg::op_relative_subroutine_call: begin
				npc = rel;
				push = 1'b1;
				cyc = bsb_pkg::CYC_CALL;
			end
			bsb_pkg::op_subroutine_exit, bsb_pkg::op_interrupt_exit: begin
				npc = stack_pc;
				pop = 1'b1;
				cyc = bsb_pkg::CYC_RET;
				if (issue_op == bsb_pkg::op_interrupt_exit) begin
					fupd = 1'b1;
					fl[bsb_pkg::FL_I] = 1'b1;
				end
			end
			bsb_pkg::op_compare_skip_equal: take = (rd_val == rr_val);
			bsb_pkg::op_compare_immediate: begin
				res = diff[7:0];
				fupd = 1'b1;
				fl[bsb_pkg::FL_Z] = (diff[7:0] == 8'h00);
				fl[bsb_pkg::FL_N] = diff[7];
				fl[bsb_pkg::FL_C] = diff[8];
				fl[bsb_pkg::FL_V] = (rd_val[7] & ~imm_val[7] & ~diff[7]) |
					(~rd_val[7] & imm_val[7] & diff[7]);
				fl[bsb_pkg::FL_H] = (~rd_val[3] & imm_val[3]) |
					(imm_val[3] & diff[3]) | (diff[3] & ~rd_val[3]);
			end
			bsb_pkg::op_skip_reg_bit_clear: take = !bsb_bit(rr_val, bit_sel);
			bsb_pkg::op_skip_reg_bit_set: take = bsb_bit(rr_val, bit_sel);
			bsb_pkg::op_skip_io_bit_clear: begin
				take = io_ok && !bsb_bit(io_rd_val, bit_sel);
				ioerr = !io_ok;
			end
			bsb_pkg::op_skip_io_bit_set: begin
				take = io_ok && bsb_bit(io_rd_val, bit_sel);
				ioerr = !io_ok;
			end
			bsb_pkg::op_branch_flag_set: take = bsb_bit(sr, bit_sel);
			bsb_pkg::op_branch_flag_clear: take = !bsb_bit(sr, bit_sel);
			bsb_pkg::op_branch_signed_ge:
				take = !(sr[bsb_pkg::FL_N] ^ sr[bsb_pkg::FL_V]);
			bsb_pkg::op_branch_signed_less:
				take = sr[bsb_pkg::FL_N] ^ sr[bsb_pkg::FL_V];
			bsb_pkg::op_branch_unsigned_higher_same:
				take = !sr[bsb_pkg::FL_C];
			bsb_pkg::op_branch_unsigned_lower: take = sr[bsb_pkg::FL_C];
			bsb_pkg::op_branch_half_carry_set: take = sr[bsb_pkg::FL_H];
			bsb_pkg::op_branch_half_carry_clear: take = !sr[bsb_pkg::FL_H];
			bsb_pkg::op_branch_transfer_bit_set: take = sr[bsb_pkg::FL_T];
			bsb_pkg::op_branch_transfer_bit_clear: take = !sr[bsb_pkg::FL_T];
			bsb_pkg::op_branch_overflow_set: take = sr[bsb_pkg::FL_V];
			bsb_pkg::op_branch_overflow_clear: take = !sr[bsb_pkg::FL_V];
			bsb_pkg::op_branch_irq_enabled: take = sr[bsb_pkg::FL_I];
			bsb_pkg::op_branch_irq_disabled: take = !sr[bsb_pkg::FL_I];
			bsb_pkg::op_set_io_bit, bsb_pkg::op_clear_io_bit: begin
				// A refused address still costs its two cycles but writes nothing.
				iow = io_ok;
				ioerr = !io_ok;
				cyc = bsb_pkg::CYC_IOBIT;
			end
			bsb_pkg::op_shift_left_logical: begin
				res = {rd_val[6:0], 1'b0};
				rwe = 1'b1;
				fupd = 1'b1;
				fl[bsb_pkg::FL_Z] = (res == 8'h00);
				fl[bsb_pkg::FL_C] = rd_val[7];
				fl[bsb_pkg::FL_N] = res[7];
				fl[bsb_pkg::FL_V] = res[7] ^ rd_val[7];
			end
			bsb_pkg::op_shift_right_logical: begin
				res = {1'b0, rd_val[7:1]};
				rwe = 1'b1;
				fupd = 1'b1;
				fl[bsb_pkg::FL_Z] = (res == 8'h00);
				fl[bsb_pkg::FL_C] = rd_val[0];
				fl[bsb_pkg::FL_N] = 1'b0;
				fl[bsb_pkg::FL_V] = rd_val[0];
			end
			default: cyc = bsb_pkg::CYC_ONE;
		endcase

		// Skips and branches share one shape: cycles follow the step taken.
		if (issue_op >= bsb_pkg::op_branch_flag_set &&
				issue_op <= bsb_pkg::op_branch_irq_disabled) begin
			npc = take ? rel : seq;
			cyc = take ? bsb_pkg::CYC_JUMP : bsb_pkg::CYC_ONE;
		end else if (issue_op == bsb_pkg::op_compare_skip_equal ||
				(issue_op >= bsb_pkg::op_skip_reg_bit_clear &&
				issue_op <= bsb_pkg::op_skip_io_bit_set)) begin
			cyc = !take ? bsb_pkg::CYC_ONE :
				(next_two_word ? bsb_pkg::CYC_SKIP2 : bsb_pkg::CYC_SKIP1);
			npc = issue_pc + {13'h0000, cyc};
		end

		// Wishbone: ack one cycle after the request, then drop it.
		state_next.ack = wb_cyc && wb_stb && !state_reg.ack;
		if (wb_cyc && wb_stb && !state_reg.ack && !wb_we) begin
			unique case (wb_adr)
				bsb_pkg::OFF_CTRL: state_next.rdat = {31'h0, state_reg.ctrl_en};
				bsb_pkg::OFF_FLAGS: state_next.rdat = {24'h0, state_reg.status_flags_register};
				bsb_pkg::OFF_STAT: state_next.rdat = {30'h0, state_reg.io_err,
					state_reg.st == bsb_pkg::st_run};
				bsb_pkg::OFF_COUNT: state_next.rdat = {16'h0, state_reg.retired};
				default: state_next.rdat = 32'h0;
			endcase
		end
		// Writes take effect at the edge where the master sees ack.
		if (wb_cyc && wb_stb && state_reg.ack && wb_we && wb_sel[0]) begin
			unique case (wb_adr)
				bsb_pkg::OFF_CTRL: state_next.ctrl_en = wb_dat_wr[bsb_pkg::CTRL_EN_BIT];
				bsb_pkg::OFF_FLAGS: state_next.status_flags_register = wb_dat_wr[7:0];
				bsb_pkg::OFF_STAT:
					if (wb_dat_wr[bsb_pkg::STAT_IOERR_BIT]) state_next.io_err = 1'b0;
				default: state_next.ctrl_en = state_reg.ctrl_en;
			endcase
		end

		// Sequencer: one-cycle ops finish at once, others count down.
		if (accept) begin
			state_next.pc_next = npc;
			state_next.result = res;
			state_next.pend_rwe = rwe;
			state_next.pend_push = push;
			state_next.pend_pop = pop;
			state_next.pend_io = iow;
			state_next.push_pc = seq;
			state_next.io_addr = io_addr[4:0];
			state_next.io_idx = bit_sel;
			state_next.io_val = (issue_op == bsb_pkg::op_set_io_bit);
			if (fupd) begin
				state_next.status_flags_register = fl;
			end
			if (ioerr) begin
				state_next.io_err = 1'b1;
			end
			if (cyc == bsb_pkg::CYC_ONE) begin
				state_next.done = 1'b1;
			end else begin
				state_next.st = bsb_pkg::st_run;
				state_next.cnt = cyc - 3'h1;
			end
		end else if (state_reg.st == bsb_pkg::st_run) begin
			state_next.cnt = state_reg.cnt - 3'h1;
			if (state_reg.cnt == 3'h1) begin
				state_next.done = 1'b1;
				state_next.st = bsb_pkg::st_idle;
			end
		end
		if (state_reg.done) begin
			state_next.retired = state_reg.retired + 16'h0001;
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	// Synchronous reset clears every field, then restores the enable.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_reg <= '0;
			state_reg.ctrl_en <= bsb_pkg::CTRL_EN_RST;
			state_reg.status_flags_register <= bsb_pkg::FLAGS_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking bsb_cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	a_clear_bits_result: assert property (
		accept && issue_op == bsb_pkg::op_clear_bits_immediate |=>
		done && result == ($past(rd_val) & ~$past(imm_val)) && result_we)
		else $error("clear bits result wrong");

	a_test_keeps_value: assert property (
		accept && issue_op == bsb_pkg::op_test_sign_zero |=>
		done && !result_we && flags[bsb_pkg::FL_Z] == ($past(rd_val) == 8'h00))
		else $error("test instruction wrong");

	a_zero_reg_flags: assert property (
		accept && issue_op == bsb_pkg::op_zero_register |=>
		result == 8'h00 && flags[bsb_pkg::FL_Z] && !flags[bsb_pkg::FL_V])
		else $error("register clear wrong");

	a_indirect_jump_two_cycles: assert property (
		accept && issue_op == bsb_pkg::op_indirect_jump |=>
		!done ##1 (done && pc_next == $past(z_ptr, 2)))
		else $error("indirect jump timing or target wrong");

	a_indirect_subroutine_call_three: assert property (
		accept && issue_op == bsb_pkg::op_indirect_subroutine_call |=>
		!done [*2] ##1 (done && stack_push))
		else $error("indirect call timing wrong");

	a_compare_skip_equal_skip_pc: assert property (
		accept && issue_op == bsb_pkg::op_compare_skip_equal &&
		rd_val == rr_val && !next_two_word |=>
		!done ##1 (done && pc_next == $past(issue_pc, 2) + 16'h0002))
		else $error("compare skip wrong");

	a_cpi_flags: assert property (
		accept && issue_op == bsb_pkg::op_compare_immediate |=>
		done && !result_we &&
		flags[bsb_pkg::FL_C] == ($past(rd_val) < $past(imm_val)) &&
		flags[bsb_pkg::FL_Z] == ($past(rd_val) == $past(imm_val)))
		else $error("compare immediate flags wrong");

	a_branch_signed_ge_taken: assert property (
		accept && issue_op == bsb_pkg::op_branch_signed_ge &&
		(flags[bsb_pkg::FL_N] ^ flags[bsb_pkg::FL_V]) == 1'b0 |=>
		!done ##1 done)
		else $error("signed branch timing wrong");

	a_io_range: assert property (
		io_bit_we |-> $past(io_addr, 2) <= bsb_pkg::IO_BIT_LIMIT)
		else $error("I/O bit write outside range");

	a_lsl_shift: assert property (
		accept && issue_op == bsb_pkg::op_shift_left_logical |=>
		result == {$past(rd_val[6:0]), 1'b0} &&
		flags[bsb_pkg::FL_C] == $past(rd_val[7]))
		else $error("left shift wrong");

	a_lsr_shift: assert property (
		accept && issue_op == bsb_pkg::op_shift_right_logical |=>
		result == {1'b0, $past(rd_val[7:1])} && !flags[bsb_pkg::FL_N])
		else $error("right shift wrong");

endmodule : bsb_exec

`default_nettype wire

// ==== sim/tb_branch_skip_bit_logic.sv ====
// Self-checking bench for the branch, skip and bit execution slice.
`timescale 1ns/100ps
`default_nettype none
module tb_branch_skip_bit_logic;
	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	logic clk, sys_rst, wb_cyc, wb_stb, wb_we, wb_ack, issue_valid;
	logic issue_ready, next_two_word, done, result_we, stack_push;
	logic stack_pop, io_bit_we, io_bit_val, iow_s, push_s, pop_s, rwe_s;
	logic [7:0] wb_adr, rd_val, rr_val, imm_val, io_rd_val, result, flags;
	logic [3:0] wb_sel;
	logic [31:0] wb_dat_wr, wb_dat_rd, q;
	bsb_pkg::bsb_op_t issue_op;
	logic [15:0] issue_pc, z_ptr, stack_pc, pc_next, push_pc;
	logic [2:0] bit_sel, io_bit_index;
	logic [11:0] rel_offset;
	logic [5:0] io_addr;
	logic [4:0] io_bit_addr;
	int err_total, tests_run, ncyc, cycles;

	bsb_exec bsb_exec_i (.clk, .sys_rst, .wb_cyc, .wb_stb, .wb_we, .wb_adr,
		.wb_sel, .wb_dat_wr, .wb_dat_rd, .wb_ack, .issue_valid, .issue_ready,
		.issue_op, .issue_pc, .rd_val, .rr_val, .imm_val, .bit_sel,
		.rel_offset, .next_two_word, .z_ptr, .stack_pc, .io_addr, .io_rd_val,
		.done, .pc_next, .result, .result_we, .flags, .stack_push, .push_pc,
		.stack_pop, .io_bit_we, .io_bit_addr, .io_bit_index, .io_bit_val);

	// ------------------------------------------------------------------
	// Clock and hang guard
	// ------------------------------------------------------------------
	// The clock toggles every 20 ns, half of its 40 ns period.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// A run far beyond the expected few hundred cycles is a hang.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			final_report();
		end
	end

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// One classic cycle; ack and read data are taken at the rising edge
	// where ack is seen high, and the request is released at that edge.
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat_wr <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 20);
		chk(wb_ack, 1'b1);
		q = wb_dat_rd;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask : wb

	// Offer one instruction and count cycles from the accept edge to done.
	task automatic run(input bsb_pkg::bsb_op_t op, input logic [7:0] a, b, k,
		input logic [2:0] bs, input logic two, input logic [5:0] ia,
		input logic [7:0] iv);
		repeat (20) begin
			@(negedge clk);
			if (issue_ready === 1'b1) break;
		end
		@(posedge clk);
		issue_valid <= 1'b1;
		issue_op <= op;
		rd_val <= a;
		rr_val <= b;
		imm_val <= k;
		bit_sel <= bs;
		next_two_word <= two;
		io_addr <= ia;
		io_rd_val <= iv;
		@(posedge clk);
		issue_valid <= 1'b0;
		ncyc = 0;
		repeat (8) begin
			@(negedge clk);
			ncyc++;
			if (done === 1'b1) break;
		end
		iow_s = io_bit_we;
		rwe_s = result_we;
		push_s = stack_push;
		pop_s = stack_pop;
	endtask : run

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic op1(input bsb_pkg::bsb_op_t op, input logic [7:0] a, k,
		r, f);
		run(op, a, a, k, 3'h0, 1'b0, 6'h00, 8'h00);
		chk(ncyc, 1);
		chk(result, r);
		chk(flags, f);
		chk(rwe_s, op != bsb_pkg::op_test_sign_zero &&
			op != bsb_pkg::op_compare_immediate);
	endtask : op1

	// Skip length follows the size of the instruction being stepped over.
	task automatic sk(input bsb_pkg::bsb_op_t op, input logic [7:0] a, b,
		input logic two, input logic [5:0] ia, input logic s);
		int n;
		n = s ? (two ? 3 : 2) : 1;
		run(op, a, b, 8'h00, 3'h5, two, ia, a);
		chk(ncyc, n);
		chk(pc_next, 16'h0100 + n[15:0]);
	endtask : sk

	task automatic io(input bsb_pkg::bsb_op_t op, input logic [5:0] ia,
		input logic we, v);
		run(op, 8'h00, 8'h00, 8'h00, 3'h3, 1'b0, ia, 8'hA5);
		chk(ncyc, 2);
		chk(iow_s, we);
		chk(flags, 8'h5A);
		if (we) begin
			chk({io_bit_addr, io_bit_index, io_bit_val}, {ia[4:0], 3'h3, v});
		end
	endtask : io

	task automatic jp(input bsb_pkg::bsb_op_t op, input logic [15:0] pc,
		input int n, input logic pu, po);
		run(op, 8'h00, 8'h00, 8'h00, 3'h0, 1'b0, 6'h00, 8'h00);
		chk(ncyc, n);
		chk(pc_next, pc);
		chk({push_s, pop_s}, {pu, po});
		if (pu) chk(push_pc, 16'h0101);
	endtask : jp

	// Each branch against three flag patterns; taken goes back 16 words.
	task automatic t_branch;
		logic [7:0] pat [3] = '{8'h00, 8'h55, 8'hAA};
		int bi [14] = '{3, 3, 3, 3, 0, 0, 5, 5, 6, 6, 3, 3, 7, 7};
		logic v, tk;
		for (int o = 16; o < 30; o++) begin
			for (int p = 0; p < 3; p++) begin
				wb(1'b1, bsb_pkg::OFF_FLAGS, {24'h0, pat[p]});
				run(bsb_pkg::bsb_op_t'(o), 8'h00, 8'h00, 8'h00, 3'h3, 1'b0,
					6'h00, 8'h00);
				v = (o == 18 || o == 19) ? pat[p][2] ^ pat[p][3] : pat[p][bi[o-16]];
				tk = v ^ o[0] ^ (o >= 18 && o <= 21);
				chk(pc_next, tk ? 16'h00F1 : 16'h0101);
				chk(ncyc, tk ? 2 : 1);
				chk(flags, pat[p]);
			end
		end
	endtask : t_branch

	// ------------------------------------------------------------------
	// Closing
	// ------------------------------------------------------------------
	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : final_report

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		{sys_rst, wb_cyc, wb_stb, wb_we, issue_valid, next_two_word} = 6'h20;
		{wb_adr, rd_val, rr_val, imm_val, io_rd_val, bit_sel, io_addr} = '0;
		{wb_dat_wr, err_total, tests_run, cycles} = '0;
		{wb_sel, rel_offset} = {4'hF, 12'hFF0};
		issue_op = bsb_pkg::op_nop;
		{issue_pc, z_ptr, stack_pc} = {16'h0100, 16'h1234, 16'h0BCD};
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		wb(1'b0, bsb_pkg::OFF_CTRL, 0);
		chk(q, 32'h1);
		wb(1'b0, bsb_pkg::OFF_FLAGS, 0);
		chk(q, 32'h0);
		wb(1'b0, 8'h10, 0);
		chk(q, 32'h0);
		wb(1'b1, bsb_pkg::OFF_CTRL, 0);
		@(negedge clk);
		chk(issue_ready, 1'b0);
		wb(1'b1, bsb_pkg::OFF_CTRL, 1);
		op1(bsb_pkg::op_clear_bits_immediate, 8'hF5, 8'h05, 8'hF0, 8'h04);
		op1(bsb_pkg::op_zero_register, 8'h80, 8'h00, 8'h00, 8'h02);
		op1(bsb_pkg::op_test_sign_zero, 8'h80, 8'h00, 8'h80, 8'h04);
		op1(bsb_pkg::op_compare_immediate, 8'h10, 8'h01, 8'h0F, 8'h20);
		op1(bsb_pkg::op_shift_left_logical, 8'h81, 8'h00, 8'h02, 8'h29);
		op1(bsb_pkg::op_shift_right_logical, 8'h01, 8'h00, 8'h00, 8'h2B);
		t_branch();
		sk(bsb_pkg::op_compare_skip_equal, 8'h3C, 8'h3C, 1'b0, 6'h0, 1'b1);
		sk(bsb_pkg::op_compare_skip_equal, 8'h3C, 8'h3C, 1'b1, 6'h0, 1'b1);
		sk(bsb_pkg::op_compare_skip_equal, 8'h3C, 8'h3D, 1'b1, 6'h0, 1'b0);
		sk(bsb_pkg::op_skip_reg_bit_clear, 8'hDF, 8'hDF, 1'b1, 6'h0, 1'b1);
		sk(bsb_pkg::op_skip_reg_bit_clear, 8'h20, 8'h20, 1'b0, 6'h0, 1'b0);
		sk(bsb_pkg::op_skip_reg_bit_set, 8'h20, 8'h20, 1'b0, 6'h0, 1'b1);
		sk(bsb_pkg::op_skip_reg_bit_set, 8'hDF, 8'hDF, 1'b1, 6'h0, 1'b0);
		sk(bsb_pkg::op_skip_io_bit_clear, 8'hDF, 8'h0, 1'b1, 6'h1F, 1'b1);
		sk(bsb_pkg::op_skip_io_bit_set, 8'h20, 8'h0, 1'b0, 6'h1F, 1'b1);
		sk(bsb_pkg::op_skip_io_bit_set, 8'h20, 8'h0, 1'b0, 6'h20, 1'b0);
		wb(1'b0, bsb_pkg::OFF_STAT, 0);
		chk(q[1], 1'b1);
		wb(1'b1, bsb_pkg::OFF_STAT, 32'h2);
		wb(1'b0, bsb_pkg::OFF_STAT, 0);
		chk(q[1], 1'b0);
		wb(1'b1, bsb_pkg::OFF_FLAGS, 32'h5A);
		io(bsb_pkg::op_set_io_bit, 6'h1F, 1'b1, 1'b1);
		io(bsb_pkg::op_clear_io_bit, 6'h00, 1'b1, 1'b0);
		io(bsb_pkg::op_clear_io_bit, 6'h20, 1'b0, 1'b0);
		jp(bsb_pkg::op_indirect_jump, 16'h1234, 2, 1'b0, 1'b0);
		jp(bsb_pkg::op_indirect_subroutine_call, 16'h1234, 3, 1, 0);
		chk(flags, 8'h5A);
		jp(bsb_pkg::op_relative_jump, 16'h00F1, 2, 1'b0, 1'b0);
		jp(bsb_pkg::op_relative_subroutine_call, 16'h00F1, 3, 1, 0);
		jp(bsb_pkg::op_subroutine_exit, 16'h0BCD, 4, 1'b0, 1'b1);
		jp(bsb_pkg::op_interrupt_exit, 16'h0BCD, 4, 1'b0, 1'b1);
		chk(flags, 8'hDA);
		// Sixty-seven instructions were completed by the scenarios above.
		wb(1'b0, bsb_pkg::OFF_COUNT, 0);
		chk(q, 32'h43);
		final_report();
	end
endmodule : tb_branch_skip_bit_logic
`default_nettype wire
